/* File: src/ctf_pkg.sv */
// Constants, types and shared functions of the tunnel frame codec.
package ctf_pkg;
    localparam logic [1:0] FRAME_TYPE = 2'h1;
    localparam logic [5:0] MAX_PAYLOAD = 6'h1e;
    localparam logic [3:0] ADM_DATA = 4'h0;
    localparam logic [3:0] ADM_PROTO_A = 4'h8;
    localparam logic [3:0] ADM_PROTO_F = 4'h9;
    localparam logic [3:0] ADM_INIT = 4'h1;
    localparam logic [3:0] ADM_HALT = 4'h2;
    localparam logic [15:0] CRC_INIT = 16'h6363;
    localparam logic [15:0] CRC_POLY = 16'h8408;
    localparam logic [15:0] CRC_RESIDUE = 16'h0000;
    localparam logic [7:0] A_TXCFG = 8'h00;
    localparam logic [7:0] A_CMD = 8'h04;
    localparam logic [7:0] A_STATUS = 8'h08;
    localparam logic [7:0] A_RXINFO = 8'h0c;
    localparam logic [2:0] A_TXBUF_HI = 3'h2;
    localparam logic [2:0] A_RXBUF_HI = 3'h4;
    localparam int F_ADMIN = 0;
    localparam int F_STRUCT = 4;
    localparam int F_LEN = 5;
    localparam int F_BITS = 10;
    localparam logic [12:0] TXCFG_RST = 13'h0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {LK_SOF, LK_DATA, LK_EOF} ctf_kind_t;
    typedef struct packed {
        ctf_kind_t kind;
        logic [7:0] data;
    } ctf_sym_t;
    function automatic logic [15:0] ctf_crc(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {8'h00, d};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction
    function automatic logic ctf_addr_ok(input logic [7:0] a);
        return (a == A_TXCFG) || (a == A_CMD) || (a == A_STATUS) || (a == A_RXINFO) ||
            (a[7:5] == A_TXBUF_HI) || (a[7:5] == A_RXBUF_HI);
    endfunction
endpackage

/* File: src/ctf_frame_codec.sv */
// Front-end side tunnel frame builder and parser with an AXI4-Lite register slave.
//
// Chosen here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module ctf_frame_codec (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    output logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    input wire logic [7:0] s_axi_araddr_i,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic tx_valid_o,
    output ctf_pkg::ctf_sym_t tx_sym_o,
    input wire logic tx_ready_i,
    input wire logic rx_valid_i,
    input wire ctf_pkg::ctf_sym_t rx_sym_i,
    output logic rx_ready_o,
    output logic session_o,
    output logic listen_only_o,
    output logic rf_send_o,
    output logic [5:0] rf_len_o,
    output logic goto_init_o,
    output logic goto_halt_o
);
    typedef enum logic [2:0] {T_IDLE, T_SOF, T_HDR, T_PAY, T_CRCL, T_CRCH, T_EOF} ctf_tx_t;
    typedef enum logic {R_IDLE, R_BODY} ctf_rx_t;

    ////////////////////////////////////////////////////////////////////////////////
    logic [1:0] rst_ff;
    logic rst_n;
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) rst_ff <= 2'h0;
        else rst_ff <= {rst_ff[0], 1'b1};
    end
    assign rst_n = rst_ff[1];

    ////////////////////////////////////////////////////////////////////////////////
    logic aw_hold_reg, w_hold_reg, bvalid_reg, rvalid_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg, rdata_reg;
    logic [3:0] w_strb_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [12:0] txcfg_reg;
    logic [7:0] tx_mem [32];
    logic [7:0] rx_mem [32];
    logic [6:0] status_w;
    logic [9:0] rxinfo_w;
    wire aw_fire = s_axi_awvalid_i && s_axi_awready_o;
    wire w_fire = s_axi_wvalid_i && s_axi_wready_o;
    wire ar_fire = s_axi_arvalid_i && s_axi_arready_o;
    wire wr_fire = aw_hold_reg && w_hold_reg && !bvalid_reg;
    wire wr_ok = ctf_pkg::ctf_addr_ok(aw_addr_reg);
    wire wr_cfg = wr_fire && aw_addr_reg == ctf_pkg::A_TXCFG;
    wire wr_cmd = wr_fire && aw_addr_reg == ctf_pkg::A_CMD && w_strb_reg[0];
    wire wr_buf = wr_fire && aw_addr_reg[7:5] == ctf_pkg::A_TXBUF_HI;
    wire start_req = wr_cmd && w_data_reg[0];
    wire end_req = wr_cmd && w_data_reg[1];
    wire [6:0] st_clr = (wr_fire && aw_addr_reg == ctf_pkg::A_STATUS && w_strb_reg[0]) ?
        w_data_reg[6:0] : 7'h00;
    wire [4:0] rd_base = {s_axi_araddr_i[4:2], 2'h0};
    wire [31:0] rd_tx = {tx_mem[rd_base + 5'h3], tx_mem[rd_base + 5'h2],
        tx_mem[rd_base + 5'h1], tx_mem[rd_base]};
    wire [31:0] rd_rx = {rx_mem[rd_base + 5'h3], rx_mem[rd_base + 5'h2],
        rx_mem[rd_base + 5'h1], rx_mem[rd_base]};
    wire [31:0] rd_word =
        (s_axi_araddr_i == ctf_pkg::A_TXCFG) ? {19'h00000, txcfg_reg} :
        (s_axi_araddr_i == ctf_pkg::A_STATUS) ? {25'h0000000, status_w} :
        (s_axi_araddr_i == ctf_pkg::A_RXINFO) ? {22'h000000, rxinfo_w} :
        (s_axi_araddr_i[7:5] == ctf_pkg::A_TXBUF_HI) ? rd_tx :
        (s_axi_araddr_i[7:5] == ctf_pkg::A_RXBUF_HI) ? rd_rx : 32'h00000000;
    assign s_axi_awready_o = !aw_hold_reg;
    assign s_axi_wready_o = !w_hold_reg;
    assign s_axi_arready_o = !rvalid_reg;
    assign s_axi_bvalid_o = bvalid_reg;
    assign s_axi_bresp_o = bresp_reg;
    assign s_axi_rvalid_o = rvalid_reg;
    assign s_axi_rdata_o = rdata_reg;
    assign s_axi_rresp_o = rresp_reg;

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
            bresp_reg <= ctf_pkg::RESP_OKAY;
        end else begin
            if (aw_fire) aw_addr_reg <= s_axi_awaddr_i;
            if (w_fire) w_data_reg <= s_axi_wdata_i;
            if (w_fire) w_strb_reg <= s_axi_wstrb_i;
            aw_hold_reg <= (aw_hold_reg || aw_fire) && !(bvalid_reg && s_axi_bready_i);
            w_hold_reg <= (w_hold_reg || w_fire) && !(bvalid_reg && s_axi_bready_i);
            if (wr_fire) bvalid_reg <= 1'b1;
            else if (s_axi_bready_i) bvalid_reg <= 1'b0;
            if (wr_fire) bresp_reg <= wr_ok ? ctf_pkg::RESP_OKAY : ctf_pkg::RESP_SLVERR;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= ctf_pkg::RESP_OKAY;
        end else if (ar_fire) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_word;
            rresp_reg <= ctf_pkg::ctf_addr_ok(s_axi_araddr_i) ?
                ctf_pkg::RESP_OKAY : ctf_pkg::RESP_SLVERR;
        end else if (s_axi_rready_i) begin
            rvalid_reg <= 1'b0;
        end
    end

    // Payload memories hold data only, so they carry no reset.
    always_ff @(posedge clk_i) begin
        for (int b = 0; b < 4; b++) begin
            if (wr_buf && w_strb_reg[b]) tx_mem[{aw_addr_reg[4:2], 2'(b)}] <= w_data_reg[8*b +: 8];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) txcfg_reg <= ctf_pkg::TXCFG_RST;
        else if (wr_cfg && w_strb_reg[0]) txcfg_reg[7:0] <= w_data_reg[7:0];
        else if (wr_cfg && w_strb_reg[1]) txcfg_reg[12:8] <= w_data_reg[12:8];
    end

    ////////////////////////////////////////////////////////////////////////////////
    ctf_tx_t tx_st_reg;
    logic [7:0] tx_hdr_reg;
    logic [5:0] tx_len_reg, tx_idx_reg;
    logic [2:0] tx_bits_reg;
    logic [15:0] tx_crc_reg;
    ctf_pkg::ctf_sym_t buf0_reg, buf1_reg;
    logic [1:0] buf_cnt_reg;
    wire [3:0] cfg_admin = txcfg_reg[ctf_pkg::F_ADMIN +: 4];
    wire [5:0] cfg_len = {1'b0, txcfg_reg[ctf_pkg::F_LEN +: 5]};
    wire cfg_admin_ok = cfg_admin == ctf_pkg::ADM_DATA ||
        cfg_admin == ctf_pkg::ADM_PROTO_A || cfg_admin == ctf_pkg::ADM_PROTO_F;
    wire cfg_ok = cfg_admin_ok && cfg_len <= ctf_pkg::MAX_PAYLOAD;
    wire tx_go = start_req && tx_st_reg == T_IDLE && cfg_ok;
    wire tx_refuse = start_req && !(tx_st_reg == T_IDLE && cfg_ok);
    wire [8:0] keep_w = (9'h001 << tx_bits_reg) - 9'h001;
    wire last_pay = tx_idx_reg == tx_len_reg - 6'h01;
    wire mask_last = !tx_hdr_reg[4] && last_pay && tx_bits_reg != 3'h0;
    wire [7:0] pay_byte = tx_mem[tx_idx_reg[4:0]] & (mask_last ? keep_w[7:0] : 8'hff);
    wire fill_ready = buf_cnt_reg != 2'h2;
    wire fill_valid = tx_st_reg != T_IDLE;
    wire push = fill_valid && fill_ready;
    wire pop = tx_ready_i && buf_cnt_reg != 2'h0;
    ctf_pkg::ctf_sym_t fill_sym;
    assign fill_sym.kind = (tx_st_reg == T_SOF) ? ctf_pkg::LK_SOF :
        (tx_st_reg == T_EOF) ? ctf_pkg::LK_EOF : ctf_pkg::LK_DATA;
    assign fill_sym.data = (tx_st_reg == T_HDR) ? tx_hdr_reg :
        (tx_st_reg == T_PAY) ? pay_byte :
        (tx_st_reg == T_CRCL) ? tx_crc_reg[7:0] :
        (tx_st_reg == T_CRCH) ? tx_crc_reg[15:8] : 8'h00;
    assign tx_valid_o = buf_cnt_reg != 2'h0;
    assign tx_sym_o = buf0_reg;

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            tx_st_reg <= T_IDLE;
            tx_hdr_reg <= 8'h00;
            tx_len_reg <= 6'h00;
            tx_idx_reg <= 6'h00;
            tx_bits_reg <= 3'h0;
            tx_crc_reg <= ctf_pkg::CRC_INIT;
        end else if (tx_go) begin
            tx_st_reg <= T_SOF;
            tx_hdr_reg <= {ctf_pkg::FRAME_TYPE, 1'b0, txcfg_reg[4:0]};
            tx_len_reg <= cfg_len;
            tx_bits_reg <= txcfg_reg[ctf_pkg::F_BITS +: 3];
            tx_idx_reg <= 6'h00;
            tx_crc_reg <= ctf_pkg::CRC_INIT;
        end else if (push) begin
            if (tx_st_reg == T_HDR || tx_st_reg == T_PAY) begin
                tx_crc_reg <= ctf_pkg::ctf_crc(tx_crc_reg, fill_sym.data);
            end
            if (tx_st_reg == T_PAY) tx_idx_reg <= tx_idx_reg + 6'h01;
            unique case (tx_st_reg)
                T_SOF: tx_st_reg <= T_HDR;
                T_HDR: tx_st_reg <= (tx_len_reg == 6'h00) ? T_CRCL : T_PAY;
                T_PAY: tx_st_reg <= last_pay ? T_CRCL : T_PAY;
                T_CRCL: tx_st_reg <= T_CRCH;
                T_CRCH: tx_st_reg <= T_EOF;
                T_EOF: tx_st_reg <= T_IDLE;
                T_IDLE: tx_st_reg <= T_IDLE;
            endcase
        end
    end

    // Two entries let the builder keep going for one cycle after the link stalls.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            buf0_reg <= '{kind: ctf_pkg::LK_SOF, data: 8'h00};
            buf1_reg <= '{kind: ctf_pkg::LK_SOF, data: 8'h00};
            buf_cnt_reg <= 2'h0;
        end else begin
            if (pop) buf0_reg <= buf1_reg;
            if (push && (buf_cnt_reg == 2'h0 || (buf_cnt_reg == 2'h1 && pop))) buf0_reg <= fill_sym;
            else if (push) buf1_reg <= fill_sym;
            buf_cnt_reg <= buf_cnt_reg + {1'b0, push} - {1'b0, pop};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    ctf_rx_t rx_st_reg;
    logic [5:0] rx_cnt_reg;
    logic [7:0] rx_hdr_reg;
    logic [15:0] rx_crc_reg;
    logic [9:0] rxinfo_reg;
    logic rx_done_reg, refused_reg, discard_reg, crc_err_reg, session_reg, listen_reg;
    logic rf_send_reg, init_reg, halt_reg;
    logic [5:0] rf_len_reg;
    wire rx_byte = rx_valid_i && rx_sym_i.kind == ctf_pkg::LK_DATA && rx_st_reg == R_BODY;
    wire rx_end = rx_valid_i && rx_sym_i.kind == ctf_pkg::LK_EOF && rx_st_reg == R_BODY;
    wire [5:0] rx_plen = rx_cnt_reg - 6'h03;
    wire rx_crc_ok = rx_crc_reg == ctf_pkg::CRC_RESIDUE && rx_cnt_reg >= 6'h03;
    wire rx_tunnel = rx_hdr_reg[7:6] == ctf_pkg::FRAME_TYPE;
    wire [3:0] rx_admin = rx_hdr_reg[3:0];
    wire rx_admin_ok = rx_admin == ctf_pkg::ADM_DATA ||
        rx_admin == ctf_pkg::ADM_INIT || rx_admin == ctf_pkg::ADM_HALT;
    wire rx_bad = rx_hdr_reg[5] || rx_plen > ctf_pkg::MAX_PAYLOAD;
    wire ev_wll = rx_end && rx_crc_ok && !rx_tunnel;
    wire ev_drop = rx_end && rx_crc_ok && rx_tunnel && (rx_bad || !rx_admin_ok);
    wire ev_acc = rx_end && rx_crc_ok && rx_tunnel && !rx_bad && rx_admin_ok;
    wire ev_crc = rx_end && !rx_crc_ok;
    wire tx_done = push && tx_st_reg == T_EOF;
    assign rx_ready_o = 1'b1;
    assign status_w = {listen_reg, crc_err_reg, discard_reg, refused_reg, rx_done_reg,
        session_reg, tx_st_reg != T_IDLE};
    assign rxinfo_w = rxinfo_reg;
    assign session_o = session_reg;
    assign listen_only_o = listen_reg;
    assign rf_send_o = rf_send_reg;
    assign rf_len_o = rf_len_reg;
    assign goto_init_o = init_reg;
    assign goto_halt_o = halt_reg;

    // Bytes of a frame that is later dropped still land in the receive memory.
    always_ff @(posedge clk_i) begin
        if (rx_byte && rx_cnt_reg != 6'h00 && rx_cnt_reg <= 6'h20) begin
            rx_mem[5'(rx_cnt_reg - 6'h01)] <= rx_sym_i.data;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rx_st_reg <= R_IDLE;
            rx_cnt_reg <= 6'h00;
            rx_hdr_reg <= 8'h00;
            rx_crc_reg <= ctf_pkg::CRC_INIT;
        end else if (rx_valid_i && rx_sym_i.kind == ctf_pkg::LK_SOF) begin
            rx_st_reg <= R_BODY;
            rx_cnt_reg <= 6'h00;
            rx_crc_reg <= ctf_pkg::CRC_INIT;
        end else if (rx_byte) begin
            if (rx_cnt_reg == 6'h00) rx_hdr_reg <= rx_sym_i.data;
            if (rx_cnt_reg != 6'h3f) rx_cnt_reg <= rx_cnt_reg + 6'h01;
            rx_crc_reg <= ctf_pkg::ctf_crc(rx_crc_reg, rx_sym_i.data);
        end else if (rx_end) begin
            rx_st_reg <= R_IDLE;
        end
    end

    // Hardware events take priority over a software clear in the same cycle.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rx_done_reg <= 1'b0;
            refused_reg <= 1'b0;
            discard_reg <= 1'b0;
            crc_err_reg <= 1'b0;
            session_reg <= 1'b0;
            listen_reg <= 1'b0;
            rxinfo_reg <= 10'h000;
        end else begin
            rx_done_reg <= ev_acc || (rx_done_reg && !st_clr[2]);
            refused_reg <= tx_refuse || (refused_reg && !st_clr[3]);
            discard_reg <= ev_drop || (discard_reg && !st_clr[4]);
            crc_err_reg <= ev_crc || (crc_err_reg && !st_clr[5]);
            session_reg <= tx_go || (session_reg && !ev_wll && !end_req);
            listen_reg <= tx_done || (listen_reg && !ev_acc);
            if (ev_acc) rxinfo_reg <= {rx_plen[4:0], rx_hdr_reg[4:0]};
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rf_send_reg <= 1'b0;
            rf_len_reg <= 6'h00;
            init_reg <= 1'b0;
            halt_reg <= 1'b0;
        end else begin
            rf_send_reg <= ev_acc && rx_plen != 6'h00;
            if (ev_acc) rf_len_reg <= rx_plen;
            init_reg <= ev_acc && rx_admin == ctf_pkg::ADM_INIT;
            halt_reg <= ev_acc && rx_admin == ctf_pkg::ADM_HALT;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n);
    sequence s_crc_out;
        (tx_st_reg == T_CRCL && push) ##[1:8] (tx_st_reg == T_CRCH && push);
    endsequence
    sequence s_sof_out;
        tx_st_reg == T_SOF && push;
    endsequence
    AST_HDR_TYPE: assert property ((tx_st_reg == T_HDR && push) |->
        fill_sym.data[7:5] == 3'h2) else $error("Header type bits wrong.");
    AST_SOF_THEN_HDR: assert property (s_sof_out |=> tx_st_reg == T_HDR)
        else $error("Header did not follow start.");
    AST_CRC_THEN_EOF: assert property (s_crc_out |=> tx_st_reg == T_EOF)
        else $error("End did not follow check value.");
    AST_LEN_LIMIT: assert property ((tx_st_reg != T_IDLE) |-> tx_len_reg <= 6'h1e)
        else $error("Payload longer than allowed.");
    AST_ADMIN_LEGAL: assert property ((tx_st_reg == T_HDR && push) |->
        fill_sym.data[3:0] inside {4'h0, 4'h8, 4'h9}) else $error("Reserved code sent.");
    AST_STRUCT_BIT: assert property (tx_go |=> tx_hdr_reg[4] == $past(txcfg_reg[4]))
        else $error("Structure bit not carried.");
    AST_RF_NONEMPTY: assert property (rf_send_o |-> rf_len_o != 6'h00 &&
        $past(ev_acc)) else $error("Empty data forwarded.");
    AST_DROP_SILENT: assert property ((rx_end && rx_hdr_reg[5]) |=>
        !rf_send_o && !goto_init_o && !goto_halt_o) else $error("Dropped frame leaked.");
    AST_RESERVED_KEEP: assert property ((rx_end && rx_tunnel && !rx_admin_ok &&
        !tx_go && !end_req) |=> $stable(session_o)) else $error("Reserved frame changed session.");
    AST_WLL_ENDS: assert property ((ev_wll && !tx_go) |=> !session_o)
        else $error("Session survived link-layer frame.");
    AST_BUF_HOLD: assert property ((buf_cnt_reg == 2'h2 && !tx_ready_i) |=>
        buf_cnt_reg == 2'h2 && $stable(tx_sym_o)) else $error("Buffer lost a word.");
endmodule // ctf_frame_codec

/* File: verif/ctf_card_model.sv */
// Card-side link peer that absorbs the sent symbols and sends frames on request.
`timescale 1ns/1ps
module ctf_card_model (
    input wire logic clk_i,
    input wire logic tx_valid_i,
    input wire ctf_pkg::ctf_sym_t tx_sym_i,
    output logic tx_ready_o,
    output logic rx_valid_o,
    output ctf_pkg::ctf_sym_t rx_sym_o,
    input wire logic rx_ready_i
);
    logic stall = 1'b0;
    logic [1:0] ph = 2'h0;
    ctf_pkg::ctf_sym_t seen_q[$];
    initial begin
        tx_ready_o = 1'b0;
        rx_valid_o = 1'b0;
        rx_sym_o = '0;
    end
    // Stalling two cycles in four keeps the sender's buffer full for a while.
    always @(posedge clk_i) begin
        ph <= ph + 2'h1;
        tx_ready_o <= !stall || ph[1];
        if (tx_valid_i && tx_ready_o) begin
            seen_q.push_back(tx_sym_i);
        end
    end
    function automatic logic [15:0] crc16(input logic [7:0] b[$]);
        logic [15:0] c;
        c = ctf_pkg::CRC_INIT;
        foreach (b[i]) begin
            c = c ^ {8'h00, b[i]};
            for (int k = 0; k < 8; k++) begin
                c = c[0] ? ((c >> 1) ^ ctf_pkg::CRC_POLY) : (c >> 1);
            end
        end
        return c;
    endfunction
    task automatic put(input ctf_pkg::ctf_kind_t k, input logic [7:0] d);
        rx_valid_o <= 1'b1;
        rx_sym_o <= '{k, d};
        @(posedge clk_i);
        while (rx_ready_i !== 1'b1) @(posedge clk_i);
    endtask
    // The header and any admin code come from the bench, reserved ones only when it asks.
    task automatic send_frame(input logic [7:0] b[$], input logic bad);
        logic [15:0] c;
        c = crc16(b) ^ {15'h0000, bad};
        b.push_back(c[7:0]);
        b.push_back(c[15:8]);
        put(ctf_pkg::LK_SOF, 8'h00);
        foreach (b[i]) put(ctf_pkg::LK_DATA, b[i]);
        put(ctf_pkg::LK_EOF, 8'h00);
        rx_valid_o <= 1'b0;
        rx_sym_o <= ctf_pkg::ctf_sym_t'(~rx_sym_o);
    endtask
endmodule // ctf_card_model

/* File: verif/contactless_tunnel_frame_codec_test.sv */
// Self-checking bench for the tunnel frame codec against a card-side peer.
`timescale 1ns/1ps
module contactless_tunnel_frame_codec_test;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, tx_valid, tx_ready, rx_valid, rx_ready;
    logic [1:0] bresp, rresp, resp;
    ctf_pkg::ctf_sym_t tx_sym, rx_sym;
    logic session, listen, rf_send, goto_init, goto_halt;
    logic [5:0] rf_len;
    int n_fail = 0, checks = 0, cyc = 0, n_rf = 0, n_init = 0, n_halt = 0;
    ctf_frame_codec DUT (.clk_i(clk), .nrst_i(nrst),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_awaddr_i(awaddr),
        .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(wstrb), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_bresp_o(bresp), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_araddr_i(araddr), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .tx_valid_o(tx_valid),
        .tx_sym_o(tx_sym), .tx_ready_i(tx_ready), .rx_valid_i(rx_valid), .rx_sym_i(rx_sym),
        .rx_ready_o(rx_ready), .session_o(session), .listen_only_o(listen),
        .rf_send_o(rf_send), .rf_len_o(rf_len), .goto_init_o(goto_init),
        .goto_halt_o(goto_halt));
    ctf_card_model u_card (.clk_i(clk), .tx_valid_i(tx_valid), .tx_sym_i(tx_sym),
        .tx_ready_o(tx_ready), .rx_valid_o(rx_valid), .rx_sym_o(rx_sym),
        .rx_ready_i(rx_ready));
    initial begin
        forever #2 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Pulses are counted here so that no scenario can miss a one-cycle output.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        n_rf <= n_rf + int'(rf_send === 1'b1);
        n_init <= n_init + int'(goto_init === 1'b1);
        n_halt <= n_halt + int'(goto_halt === 1'b1);
        if (cyc == 30000) begin
            n_fail = n_fail + 1;
            report_and_stop();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %0t %s got %h want %h", $time, what, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        @(posedge clk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge clk);
            if (!aw && awready === 1'b1) begin
                aw = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w && wready === 1'b1) begin
                w = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_regs();
        logic [31:0] d;
        rd(ctf_pkg::A_TXCFG, d);
        check(d, 32'h0, "txcfg reset");
        rd(ctf_pkg::A_STATUS, d);
        check(d, 32'h0, "status reset");
        rd(8'h30, d);
        check(d, 32'h0, "unmapped read");
        check(resp, ctf_pkg::RESP_SLVERR, "unmapped read resp");
        wr(8'h30, 32'h1, 4'hf);
        check(resp, ctf_pkg::RESP_SLVERR, "unmapped write");
        for (int i = 0; i < 8; i++) wr(8'h40 + 8'(4 * i), 32'h33323130 + 32'(i) * 32'h04040404, 4'hf);
    endtask
    task automatic tx_case(input logic [3:0] adm, input logic st, input logic [4:0] len,
                           input logic [2:0] nb, input logic ok);
        logic [7:0] e[$];
        logic [31:0] d;
        logic [15:0] c;
        d = {19'h0, nb, len, st, adm};
        wr(ctf_pkg::A_TXCFG, d, 4'h1);
        wr(ctf_pkg::A_TXCFG, d, 4'h2);
        u_card.seen_q.delete();
        wr(ctf_pkg::A_CMD, 32'h1, 4'h1);
        for (int t = 0; t < 200 && !(u_card.seen_q.size() != 0
            && u_card.seen_q[$].kind == ctf_pkg::LK_EOF); t++) @(posedge clk);
        e.push_back({2'b01, 1'b0, st, adm});
        for (int k = 0; k < len; k++) e.push_back(8'h30 + 8'(k));
        if (!st && nb != 0 && len != 0) e[len] = e[len] & ((8'h01 << nb) - 8'h01);
        c = u_card.crc16(e);
        e.push_back(c[7:0]);
        e.push_back(c[15:8]);
        check(u_card.seen_q.size(), ok ? e.size() + 2 : 0, "symbol count");
        if (ok) begin
            check(u_card.seen_q[0].kind, ctf_pkg::LK_SOF, "start");
            foreach (e[i]) check(u_card.seen_q[i + 1], {ctf_pkg::LK_DATA, e[i]}, "byte");
            check(u_card.seen_q[e.size() + 1].kind, ctf_pkg::LK_EOF, "end");
            check({session, listen}, 2'b11, "session");
        end
        rd(ctf_pkg::A_STATUS, d);
        check(d[3], !ok, "refused");
        wr(ctf_pkg::A_STATUS, 32'h3c, 4'h1);
    endtask
    // Outcome bits are crc error, discard, halt, init and radio forward.
    task automatic rx_case(input logic [7:0] h, input int len, input logic bad,
                           input logic [4:0] exp);
        logic [7:0] b[$];
        logic [31:0] d;
        int r0, i0, h0;
        r0 = n_rf;
        i0 = n_init;
        h0 = n_halt;
        b.push_back(h);
        for (int k = 0; k < len; k++) b.push_back(8'h70 + 8'(k));
        u_card.send_frame(b, bad);
        repeat (3) @(posedge clk);
        rd(ctf_pkg::A_STATUS, d);
        check({d[5:4], n_halt - h0 == 1, n_init - i0 == 1, n_rf - r0 == 1}, exp, "rx");
        if (exp[0]) begin
            rd(ctf_pkg::A_RXINFO, d);
            check({d[9:0], rf_len, listen}, {5'(len), h[4:0], 6'(len), 1'b0}, "info");
            rd(8'h80, d);
            check(d[15:0], 16'h7170, "rxbuf");
        end
        wr(ctf_pkg::A_STATUS, 32'h3c, 4'h1);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        t_regs();
        u_card.stall = 1'b1;
        tx_case(4'h0, 1'b1, 5'd3, 3'd0, 1'b1);
        tx_case(4'h8, 1'b1, 5'd0, 3'd0, 1'b1);
        tx_case(4'h9, 1'b1, 5'd30, 3'd0, 1'b1);
        tx_case(4'h0, 1'b0, 5'd2, 3'd3, 1'b1);
        tx_case(4'h1, 1'b1, 5'd2, 3'd0, 1'b0);
        tx_case(4'h0, 1'b1, 5'd31, 3'd0, 1'b0);
        rx_case(8'h50, 2, 1'b0, 5'b00001);
        rx_case(8'h50, 0, 1'b0, 5'b00000);
        rx_case(8'h50, 30, 1'b0, 5'b00001);
        rx_case(8'h41, 0, 1'b0, 5'b00010);
        rx_case(8'h42, 0, 1'b0, 5'b00100);
        rx_case(8'h43, 0, 1'b0, 5'b01000);
        rx_case(8'h48, 0, 1'b0, 5'b01000);
        rx_case(8'h70, 0, 1'b0, 5'b01000);
        rx_case(8'h50, 31, 1'b0, 5'b01000);
        rx_case(8'h50, 1, 1'b1, 5'b10000);
        check(session, 1'b1, "session kept");
        rx_case(8'h80, 0, 1'b0, 5'b00000);
        check(session, 1'b0, "session ended");
        tx_case(4'h0, 1'b1, 5'd1, 3'd0, 1'b1);
        wr(ctf_pkg::A_CMD, 32'h2, 4'h1);
        check(session, 1'b0, "session closed");
        report_and_stop();
    end
endmodule // contactless_tunnel_frame_codec_test
